// ===== design/cmd_parser_defines.vh
// Purpose: Constants for the ASCII remote command parser.
// Assumes: 200 MHz clock, APB register access, byte-wide links.
// Notes: Command and unit words are packed upper-case ASCII.
//
// What this block does
// - Ready flag bit 1, cleared on command arrival
// - Busy: refuse input, serial poll still answered
// - Execution done sets ready again
// - Commands run strictly one after another
// - All interfaces accepted; reply to querying one
// - Line ends on LF or GPIB EOI
// - Semicolon separated commands run in order
// - Query is mnemonic plus question mark
// - Several answers joined with semicolons
// - Letter case ignored everywhere
// - Reals as integer, fraction or exponent
// - Quoted strings accepted as arguments
// - Optional unit suffix scales set values
// - Queries answer in base units
// - Enum by index, abbreviation or full name
// - Enum query answers the index
// - Asterisk commands same on every interface
// - Error and activity flash, remote held
`ifndef CMD_PARSER_DEFINES_VH
`define CMD_PARSER_DEFINES_VH

`define CH_LF 8'h0a
`define CH_SP 8'h20
`define CH_QUOTE 8'h22
`define CH_STAR 8'h2a
`define CH_PLUS 8'h2b
`define CH_COMMA 8'h2c
`define CH_MINUS 8'h2d
`define CH_DOT 8'h2e
`define CH_ZERO 8'h30
`define CH_NINE 8'h39
`define CH_SEMI 8'h3b
`define CH_QM 8'h3f
`define CH_E 8'h45

`define CMD_FREQ 32'h46524551
`define CMD_PHASE 32'h50484153
`define CMD_VOLT 32'h534c564c
`define CMD_INPUT_TYPE 32'h49564d44
`define CMD_ERR_STATUS 32'h45525253
`define CMD_CLEAR 32'h2a434c53

`define EN_VOLT 32'h564f4c54
`define EN_CURR 32'h43555252

`define U_HZ 32'h0000485a
`define U_KHZ 32'h004b485a
`define U_MHZ 32'h004d485a
`define U_DEG 32'h00444547
`define U_MDEG 32'h4d444547
`define U_UDEG 32'h55444547
`define U_V 32'h00000056
`define U_MV 32'h00004d56
`define U_UV 32'h00005556
`define U_NV 32'h00004e56

`define IF_GPIB 2'h0
`define LINE_DEPTH 64
`define STB_READY_BIT 1
`define STB_ERR_BIT 2
`define STB_EVT_SUM_BIT 5
`define ERR_CMD_BIT 0
`define ERR_RANGE_BIT 1
`define ERR_SYNTAX_BIT 2

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_VAL_BASE 8'h08
`define CTRL_LOCK_BIT 0
`define STAT_READY_BIT 0
`define STAT_ERR_LSB 1
`define STAT_TYPE_BIT 4
`define EXP_NEG_BIT 8
`define CTRL_RST 1'b0
`define VAL_RST_BCD 32'h00000001
`define VAL_RST_EXP 8'h00

`define CLK_MHZ 200
`define FLASH_US 10000
`define FLASH_CYC (`FLASH_US * `CLK_MHZ)

`endif

// ===== design/led_stretch.v
// Purpose: Stretch short event pulses into visible indicator flashes.
// Assumes: One clock, synchronous active-high reset.
// Notes: A new event restarts the flash.
`timescale 1ns/100ps
module led_stretch #(
  parameter CYCLES = 2000000
) (
  input wire ref_clk_in, // System clock
  input wire sys_rst_in, // Synchronous reset
  input wire trig_in, // One-cycle event
  output wire led_out // Stretched flash
);
  reg [31:0] cnt_r;
  reg led_r;

  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cnt_r <= 32'h0;
      led_r <= 1'b0;
    end else if (trig_in) begin
      cnt_r <= CYCLES - 1;
      led_r <= 1'b1;
    end else if (cnt_r != 32'h0) begin
      cnt_r <= cnt_r - 32'h1;
    end else begin
      led_r <= 1'b0;
    end
  end

  assign led_out = led_r;
endmodule // led_stretch

// ===== design/cmd_parser.v
// Purpose: ASCII command line parser and executor with APB registers.
// Assumes: Link bytes are synchronous to ref_clk_in.
// Notes: Real values are kept as 8 BCD digits and a decimal exponent.
`timescale 1ns/100ps
`include "cmd_parser_defines.vh"
module cmd_parser #(
  parameter FLASH_CYCLES = `FLASH_CYC
) (
  input wire ref_clk_in, // 200 MHz clock
  input wire sys_rst_in, // Synchronous reset
  input wire [7:0] rx_byte_in, // Received character
  input wire rx_valid_in, // Character present
  input wire [1:0] rx_src_in, // Interface of character
  input wire rx_eoi_in, // GPIB end-or-identify
  output wire [3:0] rx_ready_out, // Accept per interface
  output wire [7:0] tx_byte_out, // Response character
  output wire tx_valid_out, // Response present
  output wire [1:0] tx_dst_out, // Interface to answer
  input wire tx_ready_in, // Link takes character
  output wire [7:0] stb_out, // Serial poll byte
  output wire activity_led_out, // Traffic flash
  output wire error_led_out, // Error flash
  output wire remote_led_out, // Front panel locked
  input wire [7:0] paddr_in, // APB address
  input wire psel_in, // APB select
  input wire penable_in, // APB enable
  input wire pwrite_in, // APB direction
  input wire [31:0] pwdata_in, // APB write data
  output wire [31:0] prdata_out, // APB read data
  output wire pready_out, // APB ready
  output wire pslverr_out // APB unmapped
);
  localparam S_RX = 3'h0, S_PARSE = 3'h1, S_EXEC = 3'h2;
  localparam S_SEND = 3'h3, S_NEXT = 3'h4, S_DONE = 3'h5;
  localparam P_MN = 3'h0, P_GAP = 3'h1, P_INT = 3'h2, P_FRAC = 3'h3;
  localparam P_EXP = 3'h4, P_WORD = 3'h5, P_STR = 3'h6;
  localparam C_NONE = 3'h0, C_FREQ = 3'h1, C_PHAS = 3'h2, C_VOLT = 3'h3;
  localparam C_TYPE = 3'h4, C_ERRQ = 3'h5, C_CLS = 3'h6, C_BAD = 3'h7;

  reg [7:0] line_mem [0:`LINE_DEPTH-1];
  reg [6:0] wr_ix_r, rd_ix_r;
  reg [2:0] st_r, ph_r;
  reg [3:0] rdy_r;
  reg [1:0] src_r;
  reg ready_r, ovf_r, last_r, end_r, first_r;
  reg [31:0] mnem_r, word_r, bcd_r;
  reg [3:0] mlen_r, wlen_r, ndig_r, narg_r;
  reg [7:0] exp_r;
  reg [6:0] eacc_r;
  reg query_r, sp_r, neg_r, eneg_r, num_r, real_r, bad_r;
  reg [2:0] err_r;
  reg errsum_r, in_type_r, ctrl_r;
  reg [31:0] vbcd [0:2];
  reg [7:0] vexp [0:2];
  reg [2:0] vneg;
  reg [111:0] obuf_r;
  reg [4:0] ocnt_r;
  reg [7:0] txb_r;
  reg txv_r, actp_r, errp_r, remote_r;
  reg pready_r, pslverr_r;
  reg [31:0] prdata_r;
  integer i;

  function [7:0] upcase(input [7:0] c);
    upcase = (c >= 8'h61 && c <= 8'h7a) ? c - 8'h20 : c;
  endfunction

  function is_digit(input [7:0] c);
    is_digit = (c >= `CH_ZERO) && (c <= `CH_NINE);
  endfunction

  function is_alpha(input [7:0] c);
    is_alpha = (c >= 8'h41) && (c <= 8'h5a);
  endfunction

  function [2:0] cmd_code(input [31:0] w, input [3:0] n, input q);
    begin
      cmd_code = C_BAD;
      if (n == 4'h0 && !q)
        cmd_code = C_NONE;
      else if (n == 4'h4) begin
        case (w)
          `CMD_FREQ: cmd_code = C_FREQ;
          `CMD_PHASE: cmd_code = C_PHAS;
          `CMD_VOLT: cmd_code = C_VOLT;
          `CMD_INPUT_TYPE: cmd_code = C_TYPE;
          `CMD_ERR_STATUS: cmd_code = q ? C_ERRQ : C_BAD;
          `CMD_CLEAR: cmd_code = q ? C_BAD : C_CLS;
          default: cmd_code = C_BAD;
        endcase
      end
    end
  endfunction

  // Unit word to decimal exponent; top bit says the unit fits the kind
  function [8:0] unit_exp(input [31:0] w, input [3:0] n, input [1:0] k);
    begin
      unit_exp = 9'h000;
      if (n == 4'h0)
        unit_exp = 9'h100;
      else if (n <= 4'h4) begin
        case ({k, w})
          {2'h0, `U_HZ}: unit_exp = 9'h100;
          {2'h0, `U_KHZ}: unit_exp = 9'h103;
          {2'h0, `U_MHZ}: unit_exp = 9'h106;
          {2'h1, `U_DEG}: unit_exp = 9'h100;
          {2'h1, `U_MDEG}: unit_exp = 9'h1fd;
          {2'h1, `U_UDEG}: unit_exp = 9'h1fa;
          {2'h2, `U_V}: unit_exp = 9'h100;
          {2'h2, `U_MV}: unit_exp = 9'h1fd;
          {2'h2, `U_UV}: unit_exp = 9'h1fa;
          {2'h2, `U_NV}: unit_exp = 9'h1f7;
          default: unit_exp = 9'h000;
        endcase
      end
    end
  endfunction

  function [63:0] bcd_text(input [31:0] b);
    integer j;
    begin
      for (j = 0; j < 8; j = j + 1)
        bcd_text[8*j +: 8] = {4'h3, b[4*j +: 4]};
    end
  endfunction

  wire [7:0] ch = upcase(line_mem[rd_ix_r[5:0]]);
  wire at_end = (rd_ix_r == wr_ix_r);
  wire [2:0] cmd = cmd_code(mnem_r, mlen_r, query_r);
  wire [1:0] kind = cmd[1:0] - 2'h1;
  wire [8:0] ue = unit_exp(word_r, wlen_r, kind);
  wire [9:0] eadd = eneg_r ? -{3'h0, eacc_r} : {3'h0, eacc_r};
  wire signed [9:0] tot = {{2{exp_r[7]}}, exp_r} + eadd +
                          {{2{ue[7]}}, ue[7:0]};
  wire [7:0] sv = vexp[kind];
  wire [7:0] mag = sv[7] ? -sv : sv;
  wire [15:0] prod = {8'h00, mag} * 16'h00cd;
  wire [3:0] tens = prod[14:11];
  wire [7:0] ones = mag - {1'b0, tens, 3'b000} - {3'b000, tens, 1'b0};
  wire [103:0] num_text = {vneg[kind] ? `CH_MINUS : `CH_PLUS,
                           bcd_text(vbcd[kind]), `CH_E,
                           sv[7] ? `CH_MINUS : `CH_PLUS,
                           4'h3, tens, 4'h3, ones[3:0]};
  wire term = (rx_byte_in == `CH_LF) ||
              (rx_eoi_in && rx_src_in == `IF_GPIB);
  wire acc = rx_valid_in && rdy_r[rx_src_in] && (st_r == S_RX);

  reg [2:0] eset;
  reg store_ok, it_wr, it_val, resp_on;
  reg [103:0] resp_text;
  reg [4:0] resp_len;

  always @* begin
    eset = 3'h0;
    store_ok = 1'b0;
    it_wr = 1'b0;
    it_val = 1'b0;
    resp_on = 1'b0;
    resp_text = num_text;
    resp_len = 5'd13;
    if (bad_r && cmd != C_NONE)
      eset[`ERR_SYNTAX_BIT] = 1'b1;
    else begin
      case (cmd)
        C_FREQ, C_PHAS, C_VOLT: begin
          if (query_r)
            resp_on = 1'b1;
          else if (!num_r || narg_r != 4'h0)
            eset[`ERR_SYNTAX_BIT] = 1'b1;
          else if (!ue[8] || tot > 10'sd99 || tot < -10'sd99 ||
                   (kind != 2'h1 && (neg_r || bcd_r == 32'h0)))
            eset[`ERR_RANGE_BIT] = 1'b1;
          else
            store_ok = 1'b1;
        end
        C_TYPE: begin
          resp_text = {7'h18, in_type_r, 96'h0};
          resp_len = 5'd1;
          if (query_r)
            resp_on = 1'b1;
          else if (narg_r != 4'h0)
            eset[`ERR_SYNTAX_BIT] = 1'b1;
          else if (num_r && !real_r && !neg_r && bcd_r[31:1] == 31'h0) begin
            it_wr = 1'b1;
            it_val = bcd_r[0];
          end else if (!num_r && (wlen_r == 4'h4 || wlen_r == 4'h7) &&
                       (word_r == `EN_VOLT || word_r == `EN_CURR)) begin
            it_wr = 1'b1;
            it_val = (word_r == `EN_CURR);
          end else
            eset[`ERR_RANGE_BIT] = 1'b1;
        end
        C_ERRQ: begin
          resp_on = 1'b1;
          resp_text = {5'h06, err_r, 96'h0};
          resp_len = 5'd1;
        end
        C_BAD: eset[`ERR_CMD_BIT] = 1'b1;
        default: eset = 3'h0;
      endcase
    end
  end

  task clear_cmd;
    begin
      ph_r <= P_MN;
      mnem_r <= 32'h0;
      mlen_r <= 4'h0;
      word_r <= 32'h0;
      wlen_r <= 4'h0;
      bcd_r <= 32'h0;
      ndig_r <= 4'h0;
      narg_r <= 4'h0;
      exp_r <= 8'h00;
      eacc_r <= 7'h00;
      {query_r, sp_r, neg_r, eneg_r, num_r, real_r, bad_r} <= 7'h00;
    end
  endtask

  task push_digit;
    begin
      if (ndig_r == 4'h8) begin
        if (ph_r != P_FRAC)
          exp_r <= exp_r + 8'h01;
      end else begin
        if (bcd_r != 32'h0 || ch[3:0] != 4'h0) begin
          bcd_r <= {bcd_r[27:0], ch[3:0]};
          ndig_r <= ndig_r + 4'h1;
        end
        if (ph_r == P_FRAC)
          exp_r <= exp_r - 8'h01;
      end
    end
  endtask

  task push_word;
    begin
      if (wlen_r < 4'h4)
        word_r <= {word_r[23:0], ch};
      if (wlen_r != 4'hf)
        wlen_r <= wlen_r + 4'h1;
    end
  endtask

  always @(posedge ref_clk_in) begin
    if (acc && rx_byte_in != `CH_LF && !wr_ix_r[6])
      line_mem[wr_ix_r[5:0]] <= rx_byte_in;
  end

  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      st_r <= S_RX;
      wr_ix_r <= 7'h00;
      rd_ix_r <= 7'h00;
      rdy_r <= 4'hf;
      src_r <= 2'h0;
      {ready_r, ovf_r, last_r, end_r, first_r} <= 5'b10001;
      clear_cmd;
      err_r <= 3'h0;
      in_type_r <= 1'b0;
      for (i = 0; i < 3; i = i + 1) begin
        vbcd[i] <= `VAL_RST_BCD;
        vexp[i] <= `VAL_RST_EXP;
      end
      vneg <= 3'h0;
      obuf_r <= 112'h0;
      ocnt_r <= 5'h00;
      txb_r <= 8'h00;
      {txv_r, actp_r, errp_r} <= 3'h0;
    end else begin
      actp_r <= acc || (txv_r && tx_ready_in);
      errp_r <= 1'b0;
      if (txv_r && tx_ready_in)
        txv_r <= 1'b0;
      case (st_r)
        S_RX: begin
          if (acc) begin
            src_r <= rx_src_in;
            rdy_r <= 4'h1 << rx_src_in;
            if (rx_byte_in != `CH_LF) begin
              if (wr_ix_r[6])
                ovf_r <= 1'b1;
              else
                wr_ix_r <= wr_ix_r + 7'h01;
            end
            if (term) begin
              rdy_r <= 4'h0;
              ready_r <= 1'b0;
              if (ovf_r || (wr_ix_r[6] && rx_byte_in != `CH_LF)) begin
                err_r[`ERR_SYNTAX_BIT] <= 1'b1;
                errp_r <= 1'b1;
                st_r <= S_DONE;
              end else
                st_r <= S_PARSE;
            end
          end
        end
        S_PARSE: begin
          if (at_end || ch == `CH_SEMI) begin
            last_r <= at_end;
            if (!at_end)
              rd_ix_r <= rd_ix_r + 7'h01;
            st_r <= S_EXEC;
          end else begin
            rd_ix_r <= rd_ix_r + 7'h01;
            if (ph_r == P_STR) begin
              if (ch == `CH_QUOTE)
                ph_r <= P_GAP;
              else
                push_word;
            end else if (ch == `CH_COMMA) begin
              narg_r <= narg_r + 4'h1;
              ph_r <= P_GAP;
            end else if (ch == `CH_SP) begin
              if (mlen_r != 4'h0 || query_r) begin
                sp_r <= 1'b1;
                ph_r <= P_GAP;
              end
            end else begin
              case (ph_r)
                P_MN: begin
                  if (is_alpha(ch) || ch == `CH_STAR) begin
                    if (mlen_r < 4'h4)
                      mnem_r <= {mnem_r[23:0], ch};
                    if (mlen_r != 4'hf)
                      mlen_r <= mlen_r + 4'h1;
                  end else if (ch == `CH_QM && mlen_r != 4'h0) begin
                    query_r <= 1'b1;
                    ph_r <= P_GAP;
                  end else
                    bad_r <= 1'b1;
                end
                P_GAP: begin
                  if (!sp_r)
                    bad_r <= 1'b1;
                  else if (is_digit(ch)) begin
                    push_digit;
                    num_r <= 1'b1;
                    ph_r <= P_INT;
                  end else if (ch == `CH_MINUS || ch == `CH_PLUS) begin
                    neg_r <= (ch == `CH_MINUS);
                    num_r <= 1'b1;
                    ph_r <= P_INT;
                  end else if (ch == `CH_DOT) begin
                    {num_r, real_r} <= 2'b11;
                    ph_r <= P_FRAC;
                  end else if (ch == `CH_QUOTE)
                    ph_r <= P_STR;
                  else if (is_alpha(ch)) begin
                    push_word;
                    ph_r <= P_WORD;
                  end else
                    bad_r <= 1'b1;
                end
                P_INT, P_FRAC: begin
                  if (is_digit(ch))
                    push_digit;
                  else if (ch == `CH_DOT && ph_r == P_INT) begin
                    real_r <= 1'b1;
                    ph_r <= P_FRAC;
                  end else if (ch == `CH_E) begin
                    real_r <= 1'b1;
                    ph_r <= P_EXP;
                  end else if (is_alpha(ch)) begin
                    push_word;
                    ph_r <= P_WORD;
                  end else
                    bad_r <= 1'b1;
                end
                P_EXP: begin
                  if (is_digit(ch)) begin
                    if (eacc_r < 7'd12)
                      eacc_r <= eacc_r * 7'd10 + {3'h0, ch[3:0]};
                    else
                      eacc_r <= 7'd127;
                  end else if (ch == `CH_MINUS)
                    eneg_r <= 1'b1;
                  else if (ch != `CH_PLUS)
                    bad_r <= 1'b1;
                end
                P_WORD: begin
                  if (is_alpha(ch) || is_digit(ch))
                    push_word;
                  else
                    bad_r <= 1'b1;
                end
                default: bad_r <= 1'b1;
              endcase
            end
          end
        end
        S_EXEC: begin
          // A faulty clear keeps its own error: the set wins
          err_r <= (cmd == C_CLS && eset == 3'h0) ? 3'h0 :
                   (err_r | eset);
          errp_r <= |eset;
          if (store_ok) begin
            vbcd[kind] <= bcd_r;
            vexp[kind] <= tot[7:0];
            vneg[kind] <= neg_r;
          end
          if (it_wr)
            in_type_r <= it_val;
          if (resp_on) begin
            first_r <= 1'b0;
            if (first_r) begin
              obuf_r <= {resp_text, 8'h00};
              ocnt_r <= resp_len;
            end else begin
              obuf_r <= {`CH_SEMI, resp_text};
              ocnt_r <= resp_len + 5'h01;
            end
            st_r <= S_SEND;
          end else
            st_r <= S_NEXT;
          clear_cmd;
        end
        S_SEND: begin
          if (ocnt_r != 5'h00 && (!txv_r || tx_ready_in)) begin
            txb_r <= obuf_r[111:104];
            obuf_r <= {obuf_r[103:0], 8'h00};
            ocnt_r <= ocnt_r - 5'h01;
            txv_r <= 1'b1;
          end
          if (ocnt_r == 5'h00)
            st_r <= end_r ? S_DONE : S_NEXT;
        end
        S_NEXT: begin
          if (!last_r)
            st_r <= S_PARSE;
          else if (!first_r) begin
            obuf_r <= {`CH_LF, 104'h0};
            ocnt_r <= 5'h01;
            end_r <= 1'b1;
            st_r <= S_SEND;
          end else
            st_r <= S_DONE;
        end
        S_DONE: begin
          if (!txv_r) begin
            st_r <= S_RX;
            ready_r <= 1'b1;
            rdy_r <= 4'hf;
            wr_ix_r <= 7'h00;
            rd_ix_r <= 7'h00;
            {ovf_r, end_r, first_r} <= 3'b001;
          end
        end
        default: st_r <= S_RX;
      endcase
    end
  end

  reg [31:0] rd_val;
  reg hit;
  always @* begin
    rd_val = 32'h0;
    hit = (paddr_in[1:0] == 2'h0);
    if (paddr_in == `REG_CTRL)
      rd_val[`CTRL_LOCK_BIT] = ctrl_r;
    else if (paddr_in == `REG_STATUS) begin
      rd_val[`STAT_READY_BIT] = ready_r;
      rd_val[`STAT_ERR_LSB +: 3] = err_r;
      rd_val[`STAT_TYPE_BIT] = in_type_r;
    end else if (paddr_in >= `REG_VAL_BASE && paddr_in < 8'h20 && hit) begin
      if (!paddr_in[2])
        rd_val = vbcd[paddr_in[4:3] - 2'h1];
      else begin
        rd_val[7:0] = vexp[paddr_in[4:3] - 2'h1];
        rd_val[`EXP_NEG_BIT] = vneg[paddr_in[4:3] - 2'h1];
      end
    end else
      hit = 1'b0;
  end

  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
      ctrl_r <= `CTRL_RST;
      remote_r <= 1'b0;
      errsum_r <= 1'b0;
    end else begin
      pready_r <= psel_in && penable_in && !pready_r;
      if (psel_in && penable_in && !pready_r) begin
        prdata_r <= pwrite_in ? 32'h0 : rd_val;
        pslverr_r <= !hit;
      end
      if (psel_in && penable_in && pready_r && pwrite_in &&
          paddr_in == `REG_CTRL)
        ctrl_r <= pwdata_in[`CTRL_LOCK_BIT];
      remote_r <= ctrl_r;
      errsum_r <= |err_r;
    end
  end

  wire [1:0] flash_trig = {errp_r, actp_r};
  wire [1:0] flash_led;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : flash
      led_stretch #(
        .CYCLES(FLASH_CYCLES)
      ) u_flash (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .trig_in(flash_trig[g]),
        .led_out(flash_led[g])
      );
    end
  endgenerate
  assign activity_led_out = flash_led[0];
  assign error_led_out = flash_led[1];

  assign rx_ready_out = rdy_r;
  assign tx_byte_out = txb_r;
  assign tx_valid_out = txv_r;
  assign tx_dst_out = src_r;
  assign stb_out = {2'b00, errsum_r, 2'b00, errsum_r, ready_r, 1'b0};
  assign remote_led_out = remote_r;
  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
endmodule // cmd_parser

// ===== bench/cmd_parser_sva.sv
// Purpose: Port checks of the command parser
// Assumes: One clock, synchronous reset
// Notes: Bound into every cmd_parser
`timescale 1ns/100ps
module cmd_parser_sva (
  input wire ref_clk_in, // Clock
  input wire sys_rst_in, // Reset
  input wire [7:0] rx_byte_in, // Char
  input wire rx_valid_in, // Char present
  input wire [1:0] rx_src_in, // Source
  input wire [3:0] rx_ready_out, // Accept
  input wire [7:0] tx_byte_out, // Reply char
  input wire tx_valid_out, // Reply present
  input wire [1:0] tx_dst_out, // Reply target
  input wire tx_ready_in, // Link takes
  input wire [7:0] stb_out, // Poll byte
  input wire activity_led_out, // Traffic
  input wire error_led_out // Error flash
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  wire take = rx_valid_in && rx_ready_out[rx_src_in];
  property p_busy; !stb_out[1] |-> rx_ready_out == 4'h0; endproperty
  a_busy: assert property (p_busy) else $error("busy accept");
  property p_lf;
    take && rx_byte_in == 8'h0a |=> !stb_out[1] && rx_ready_out == 4'h0;
  endproperty
  a_lf: assert property (p_lf) else $error("ready kept");
  property p_lock;
    take |=> (rx_ready_out & ~(4'h1 << $past(rx_src_in))) == 4'h0;
  endproperty
  a_lock: assert property (p_lock) else $error("other open");
  property p_order; tx_valid_out |-> !stb_out[1]; endproperty
  a_order: assert property (p_order) else $error("ready early");
  property p_hold;
    tx_valid_out && !tx_ready_in |=> tx_valid_out &&
      $stable(tx_byte_out) && $stable(tx_dst_out);
  endproperty
  a_hold: assert property (p_hold) else $error("reply moved");
  property p_back; $fell(stb_out[1]) |-> ##[1:1000] stb_out[1]; endproperty
  a_back: assert property (p_back) else $error("never ready");
  property p_stb;
    stb_out[5] == stb_out[2] && (stb_out & 8'hd9) == 8'h00;
  endproperty
  a_stb: assert property (p_stb) else $error("poll byte");
  property p_flash; take |-> ##[1:2] activity_led_out; endproperty
  a_flash: assert property (p_flash) else $error("no flash");
  property p_errled; $rose(stb_out[2]) |-> error_led_out; endproperty
  a_errled: assert property (p_errled) else $error("no err flash");
  cover property (take && rx_byte_in == 8'h0a);
  cover property (tx_valid_out && !tx_ready_in);
  cover property ($rose(stb_out[2]));
endmodule // cmd_parser_sva
bind cmd_parser cmd_parser_sva i_sva (.*);

// ===== bench/host_link.sv
// Purpose: Host side that collects replies
// Assumes: One clock
// Notes: Slow mode stalls every other cycle
`timescale 1ns/100ps
module host_link (
  input wire ref_clk_in, // Clock
  input wire [7:0] reply_byte_in, // Reply char
  input wire reply_valid_in, // Reply present
  input wire [1:0] reply_dst_in, // Reply target
  output wire take_out // Char taken
);
  reg slow = 1'b0;
  reg tgl = 1'b0;
  reg [1:0] dst = 2'h0;
  string resp = "";
  assign take_out = !slow || tgl;
  always @(posedge ref_clk_in) begin
    tgl <= !tgl;
    if (reply_valid_in && take_out) begin
      resp = $sformatf("%s%c", resp, reply_byte_in);
      dst <= reply_dst_in;
    end
  end
endmodule // host_link

// ===== bench/ascii_remote_command_parser_bench.sv
// Purpose: Line, reply and APB tests of cmd_parser
// Assumes: FLASH_CYCLES shortened to 8
// Notes: Replies are collected by host_link
`timescale 1ns/100ps
module ascii_remote_command_parser_bench;
  reg clk = 1'b0, rst = 1'b1, rxv = 1'b0, eoi = 1'b0;
  reg ps = 1'b0, pe = 1'b0, pw = 1'b0;
  reg [7:0] rxb = 8'h00, pa = 8'h00;
  reg [1:0] src = 2'h0;
  reg [31:0] pwd = 32'h0, rd;
  wire [3:0] rdy;
  wire [7:0] txb, stb;
  wire [1:0] dst;
  wire [31:0] prd;
  wire txv, txr, act, erl, rem, prdy, perr;
  integer err_count = 0, checks = 0, n;
  string f[6] = '{"FREQ 5E3", "freq 5 khz", "FrEq .005 MHZ",
    "PHAS 12340 MDEG", "SLVL 12.3 MV", "slvl 1.23E-2"};
  real fv[6] = '{5000.0, 5000.0, 5000.0, 12.34, 0.0123, 0.0123};
  string e[6] = '{"1", "VOLT", "\"curr\"", "voltage", "CURRENT", "0"};
  string r[6] = '{"+00000005E+03\n", "+00000005E+03\n", "+00000005E+03\n",
    "+00012340E-03\n", "+00000123E-04\n", "+00000123E-04\n"};
  string it, es;
  cmd_parser #(.FLASH_CYCLES(8)) i_dut (.ref_clk_in(clk),
    .sys_rst_in(rst), .rx_byte_in(rxb), .rx_valid_in(rxv),
    .rx_src_in(src), .rx_eoi_in(eoi), .rx_ready_out(rdy),
    .tx_byte_out(txb), .tx_valid_out(txv), .tx_dst_out(dst),
    .tx_ready_in(txr), .stb_out(stb), .activity_led_out(act),
    .error_led_out(erl), .remote_led_out(rem), .paddr_in(pa),
    .psel_in(ps), .penable_in(pe), .pwrite_in(pw), .pwdata_in(pwd),
    .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr));
  host_link i_host (.ref_clk_in(clk), .reply_byte_in(txb),
    .reply_valid_in(txv), .reply_dst_in(dst), .take_out(txr));
  initial forever #2.5 clk = ~clk;
  task wrap_up;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input bit ok, input string m);
    checks++;
    if (!ok) begin
      err_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task lim(input integer b);
    if (n >= b) begin
      err_count++;
      $display("[ERR] %0t timeout", $time);
      wrap_up;
    end
  endtask
  task send(input string s, input [1:0] sr, input bit ei);
    for (int i = 0; i < s.len(); i++) begin
      rxb <= s[i];
      rxv <= 1'b1;
      src <= sr;
      eoi <= ei && i == s.len() - 1;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (rdy[sr] !== 1'b1 && n < 200);
      lim(200);
    end
    rxv <= 1'b0;
    eoi <= 1'b0;
    @(posedge clk);
    n = 0;
    while (stb[1] !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    lim(2000);
  endtask
  task q(input string s, input [1:0] sr, input string x);
    i_host.resp = "";
    send({s, "\n"}, sr, 1'b0);
    chk(i_host.resp == x, s);
    chk(i_host.dst === sr, "dst");
  endtask
  task apb(input bit w, input [7:0] a, input [31:0] d);
    pa <= a;
    pw <= w;
    pwd <= d;
    ps <= 1'b1;
    @(posedge clk);
    pe <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 50);
    lim(50);
    rd = prd;
    ps <= 1'b0;
    pe <= 1'b0;
    @(posedge clk);
  endtask
  initial begin
    // Command words built from their ASCII codes
    it = $sformatf("%s", 32'h49564d44);
    es = $sformatf("%s?", 32'h45525253);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(stb === 8'h02 && rdy === 4'hf, "reset");
    apb(0, 8'h04, 0);
    chk(rd === 32'h1, "status");
    apb(0, 8'h08, 0);
    chk(rd === 32'h1, "mantissa");
    apb(0, 8'h40, 0);
    chk(perr === 1'b1 && rd === 32'h0, "unmapped");
    apb(1, 8'h00, 1);
    repeat (2) @(posedge clk);
    chk(rem === 1'b1, "remote");
    for (int k = 0; k < 6; k++) begin
      i_host.slow <= k[0];
      send("FREQ 7;SLVL 1;PHAS 1\n", 2'(k), 1'b0);
      q({f[k], ";", f[k].substr(0, 3), "?"}, 2'(k), r[k]);
      chk(i_host.resp.len() == 14, "len");
      chk(i_host.resp.substr(0, 12).atoreal() == fv[k], f[k]);
      q({it, " ", e[k], ";", it.tolower(), "?"}, 2'(k),
        k[0] ? "0\n" : "1\n");
    end
    apb(0, 8'h1c, 0);
    chk(rd === 32'hfc, "exponent");
    q({it, " CURR;", it, "?;", es}, 3, "1;0\n");
    q({"FREQ 5 XHZ;FREQ?;", es}, 1, "+00000007E+00;2\n");
    chk(stb[2] === 1'b1, "summary");
    q({"bogu;", es}, 2, "3\n");
    apb(0, 8'h04, 0);
    chk(rd[3:1] === 3'h3, "err bits");
    q({"*cls;", es}, 0, "0\n");
    i_host.resp = "";
    send({"FREQ 1 HZ;", it, "?"}, 0, 1'b1);
    chk(i_host.resp == "1\n", "eoi");
    send({it, " 0"}, 1, 1'b0);
    chk(rdy === 4'h2 && stb[1] === 1'b1, "lock");
    send("\n", 1, 1'b0);
    wrap_up;
  end
endmodule // ascii_remote_command_parser_bench
